/* File: design/spi_master_slave_shift_core.v */
// serial shift port, master or slave, with bypassable transmit and receive fifos
// Notes on behaviour
// RQ1: master makes serial clock; slave only follows
// RQ2: shift out one edge, capture on other
// RQ3: phase bit advances data half a cycle
// RQ4: every word exchanged full duplex, unjudged
// RQ5: master starts anytime, no ready handshake
// RQ6: registers 16 bits, data in low byte
// RQ7: sixteen-deep fifos, bypassed when enable clear
// RQ8: clock period is source times divider plus one
// RQ9: odd period makes uneven halves by phase
// RQ10: master bit selects role and pin drive
// RQ11: polarity picks idle level and active edge
// RQ12: select asserted well before first clock edge
// RQ13: select held half period after last edge
// RQ14: four schemes from polarity and phase
// RQ15: word length one to sixteen bits
// RQ16: transmit can be disabled, receive only
// RQ17: slave shifts only while select is low
// RQ18: word done moves receive, loads next transmit
`timescale 1ns/1ns
`include "spi_regs.vh"

module spi_master_slave_shift_core (
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output wire [15:0] rdata,
  input wire serial_clock_pin_in,
  output wire serial_clock_pin_out,
  output wire serial_clock_pin_oe,
  input wire master_out_line_in,
  output wire master_out_line_out,
  output wire master_out_line_oe,
  input wire master_in_line_in,
  output wire master_in_line_out,
  output wire master_in_line_oe,
  input wire slave_tx_enable_line_n_in,
  output wire slave_tx_enable_line_n_out,
  output wire slave_tx_enable_line_n_oe
);

  // configuration registers
  reg [3:0] wlen_ff;
  reg pol_ff;
  reg talk_ff;
  reg master_ff;
  reg phase_ff;
  reg [6:0] baud_ff;
  reg fifo_en_ff;
  reg [7:0] tx_hi_ff;
  reg [7:0] rx_hi_ff;
  reg overrun_ff;
  reg [15:0] rdata_ff;

  // fifo storage and pointers
  reg [15:0] tx_mem [0:15];
  reg [15:0] rx_mem [0:15];
  reg [4:0] tx_wp_ff;
  reg [4:0] tx_rp_ff;
  reg [4:0] rx_wp_ff;
  reg [4:0] rx_rp_ff;

  // shift engine
  reg [3:0] st_ff;
  reg [8:0] div_ff;
  reg sck_ff;
  reg sck_prev_ff;
  reg [15:0] tx_sh_ff;
  reg [15:0] rx_sh_ff;
  reg [3:0] bit_cnt_ff;
  reg first_ff;
  reg done_ff;
  reg dout_ff;
  reg ste_ff;
  reg mosi_oe_ff;
  reg miso_oe_ff;
  reg sck_oe_ff;

  // fifo levels; with the fifo disabled each side holds a single word
  wire [4:0] tx_cnt = tx_wp_ff - tx_rp_ff;
  wire [4:0] rx_cnt = rx_wp_ff - rx_rp_ff;
  wire [4:0] fifo_lim = fifo_en_ff ? `FIFO_DEPTH : 5'h01; // [RQ7]
  wire tx_full = (tx_cnt >= fifo_lim);
  wire rx_full = (rx_cnt >= fifo_lim);
  wire tx_avail = (tx_cnt != 5'h00);
  wire rx_avail = (rx_cnt != 5'h00);

  // bus decode
  wire tx_push = wr_stb & (addr == `REG_TX_LO) & ~tx_full;
  wire rx_pop = rd_stb & (addr == `REG_RX_LO) & rx_avail;
  wire ovr_clr = wr_stb & (addr == `REG_STATUS) & wdata[`STS_OVERRUN_BIT];

  // divider: small settings fall back to divide by four, odd periods split unevenly
  wire [7:0] period = (baud_ff < `BAUD_FLOOR) ? `MIN_PERIOD : ({1'b0, baud_ff} + 8'h01); // [RQ8]
  wire [7:0] half_lo = {1'b0, period[7:1]};
  wire [7:0] half_hi = period - half_lo;
  wire [7:0] half_a = phase_ff ? half_lo : half_hi; // [RQ9]
  wire [7:0] half_b = phase_ff ? half_hi : half_lo; // [RQ9]
  wire [8:0] per9 = {1'b0, period};
  // select lead: 1.5 or 2 clock periods, less three system clocks
  wire [8:0] lead_raw = phase_ff ? ({per9[7:0], 1'b0} - `LEAD_SYSCLKS) :
                        (per9 + {2'b00, per9[7:1]} - `LEAD_SYSCLKS); // [RQ12]
  // the first clock edge is made one cycle after leaving the lead state, so count one less
  wire [8:0] lead_len = (lead_raw < 9'h002) ? 9'h001 : (lead_raw - 9'h001); // [RQ12]

  // edge events: master from its own divider, slave from the pin while selected
  wire m_tick = master_ff & ((st_ff == `ST_LEAD) | (st_ff == `ST_SHIFT)) & (div_ff == 9'h001);
  wire m_edge = m_tick & (st_ff == `ST_SHIFT);
  wire m_lead = m_edge & (sck_ff == pol_ff);
  wire s_sel = ~master_ff & ~slave_tx_enable_line_n_in & (st_ff == `ST_SHIFT);
  wire s_edge = s_sel & (serial_clock_pin_in != sck_prev_ff); // [RQ17]
  wire s_lead = s_edge & (sck_prev_ff == pol_ff);
  wire ev_lead = m_lead | s_lead; // [RQ11]
  wire ev_trail = (m_edge & ~m_lead) | (s_edge & ~s_lead); // [RQ11]

  // sample and shift edges per the four clocking schemes
  wire do_sample = phase_ff ? ev_trail : ev_lead; // [RQ2] [RQ3] [RQ14]
  // with phase set, a freshly loaded word holds its first bit over the first shift edge
  wire do_shift = (phase_ff ? ev_lead : ev_trail) & ~first_ff & ~done_ff; // [RQ2] [RQ3]
  wire sin = master_ff ? master_in_line_in : master_out_line_in;
  wire word_done = do_sample & (bit_cnt_ff == wlen_ff); // [RQ15]
  wire [15:0] rx_word = {rx_sh_ff[14:0], sin};

  // transmit word loads: master start, slave select, slave back-to-back word
  wire m_start = master_ff & (st_ff == `ST_IDLE) & tx_avail; // [RQ5]
  wire s_start = ~master_ff & (st_ff == `ST_IDLE) & ~slave_tx_enable_line_n_in;
  wire s_next = ~master_ff & word_done;
  wire load_tx = m_start | s_start | s_next; // [RQ18]
  wire tx_pop = load_tx & tx_avail;
  wire [15:0] tx_word = tx_avail ? tx_mem[tx_rp_ff[3:0]] : 16'h0000;
  wire rx_push = word_done & ~rx_full;

  // control registers and read port, upper byte ignored on write
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wlen_ff <= `RST_WLEN;
      pol_ff <= 1'b0;
      talk_ff <= 1'b0;
      master_ff <= 1'b0;
      phase_ff <= 1'b0;
      baud_ff <= `RST_BAUD;
      fifo_en_ff <= 1'b0;
      tx_hi_ff <= 8'h00;
      rdata_ff <= 16'h0000;
    end else begin
      if (wr_stb) begin
        case (addr)
          `REG_CHAR_CFG: begin
            wlen_ff <= wdata[3:0]; // [RQ15]
            pol_ff <= wdata[`CFG_POL_BIT]; // [RQ11]
          end
          `REG_OP_CTL: begin
            talk_ff <= wdata[`CTL_TALK_BIT]; // [RQ16]
            master_ff <= wdata[`CTL_MASTER_BIT]; // [RQ10]
            phase_ff <= wdata[`CTL_PHASE_BIT]; // [RQ3]
          end
          `REG_BAUD: baud_ff <= wdata[6:0];
          `REG_TX_HI: tx_hi_ff <= wdata[7:0];
          `REG_FIFO_CTL: fifo_en_ff <= wdata[`FFC_EN_BIT]; // [RQ7]
          default: ;
        endcase
      end
      // read data valid in the cycle after the strobe; upper byte reads zero
      if (rd_stb) begin
        case (addr)
          `REG_CHAR_CFG: rdata_ff <= {8'h00, 1'b0, pol_ff, 2'b00, wlen_ff}; // [RQ6]
          `REG_OP_CTL: rdata_ff <= {8'h00, 4'h0, phase_ff, master_ff, talk_ff, 1'b0};
          `REG_BAUD: rdata_ff <= {8'h00, 1'b0, baud_ff};
          `REG_TX_HI: rdata_ff <= {8'h00, tx_hi_ff};
          `REG_RX_LO: rdata_ff <= rx_avail ? {8'h00, rx_mem[rx_rp_ff[3:0]][7:0]} : 16'h0000;
          `REG_RX_HI: rdata_ff <= {8'h00, rx_hi_ff};
          `REG_STATUS: rdata_ff <= {8'h00, 4'h0, overrun_ff, (st_ff != `ST_IDLE),
                                    tx_full, rx_avail};
          `REG_FIFO_CTL: rdata_ff <= {8'h00, 1'b0, fifo_en_ff, 1'b0, tx_cnt};
          default: rdata_ff <= 16'h0000;
        endcase
      end else begin
        rdata_ff <= 16'h0000;
      end
    end
  end

  // transmit fifo: bus pushes high and low bytes as one word, engine pops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_wp_ff <= 5'h00;
      tx_rp_ff <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_wp_ff <= tx_wp_ff + 5'h01;
      end
      if (tx_pop) begin
        tx_rp_ff <= tx_rp_ff + 5'h01; // [RQ18]
      end
    end
  end

  // fifo storage has no reset
  always @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff[3:0]] <= {tx_hi_ff, wdata[7:0]};
    end
    if (rx_push) begin
      rx_mem[rx_wp_ff[3:0]] <= rx_word; // [RQ18]
    end
  end

  // receive fifo: engine pushes, low-byte read pops and latches the high byte
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_wp_ff <= 5'h00;
      rx_rp_ff <= 5'h00;
      rx_hi_ff <= 8'h00;
      overrun_ff <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wp_ff <= rx_wp_ff + 5'h01;
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 5'h01;
        rx_hi_ff <= rx_mem[rx_rp_ff[3:0]][15:8];
      end
      // a word lost to a full fifo flags overrun; the set wins over a clear
      if (word_done & rx_full) begin
        overrun_ff <= 1'b1;
      end else if (ovr_clr) begin
        overrun_ff <= 1'b0;
      end
    end
  end

  // shift engine: master state sequence and shared shift/sample datapath
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= `ST_IDLE;
      div_ff <= 9'h001;
      sck_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
      tx_sh_ff <= 16'h0000;
      rx_sh_ff <= 16'h0000;
      bit_cnt_ff <= 4'h0;
      first_ff <= 1'b1;
      done_ff <= 1'b0;
      dout_ff <= 1'b0;
      ste_ff <= 1'b1;
    end else begin
      sck_prev_ff <= serial_clock_pin_in;
      // loading a word restarts bit counting
      if (load_tx) begin
        tx_sh_ff <= tx_word;
        dout_ff <= tx_word[wlen_ff];
        rx_sh_ff <= 16'h0000;
        bit_cnt_ff <= 4'h0;
        first_ff <= 1'b1;
        done_ff <= 1'b0;
      end else begin
        if (ev_lead | ev_trail) begin
          first_ff <= 1'b0;
        end
        if (do_sample) begin
          rx_sh_ff <= rx_word; // [RQ4]
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (word_done) begin
            done_ff <= 1'b1;
          end
        end
        if (do_shift) begin
          tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
          dout_ff <= tx_sh_ff[wlen_ff - 4'h1];
        end
      end
      case (st_ff)
        `ST_IDLE: begin
          sck_ff <= pol_ff;
          ste_ff <= 1'b1;
          if (m_start) begin
            st_ff <= `ST_LEAD; // [RQ1]
            ste_ff <= 1'b0; // [RQ12]
            div_ff <= lead_len;
          end else if (s_start) begin
            st_ff <= `ST_SHIFT; // [RQ17]
          end
        end
        `ST_LEAD: begin
          if (~master_ff) begin
            st_ff <= `ST_IDLE;
          end else if (m_tick) begin
            st_ff <= `ST_SHIFT;
            div_ff <= 9'h001; // [RQ12]
          end else begin
            div_ff <= div_ff - 9'h001;
          end
        end
        `ST_SHIFT: begin
          if (master_ff) begin
            if (m_tick) begin
              sck_ff <= ~sck_ff; // [RQ1]
              if (ev_trail & (done_ff | word_done)) begin
                st_ff <= `ST_TRAIL;
                div_ff <= {1'b0, half_lo}; // [RQ13]
              end else begin
                div_ff <= {1'b0, m_lead ? half_a : half_b}; // [RQ9]
              end
            end else begin
              div_ff <= div_ff - 9'h001;
            end
          end else if (slave_tx_enable_line_n_in) begin
            st_ff <= `ST_IDLE; // [RQ17]
          end
        end
        `ST_TRAIL: begin
          if (div_ff == 9'h001) begin
            st_ff <= `ST_IDLE;
            ste_ff <= 1'b1; // [RQ13]
          end else begin
            div_ff <= div_ff - 9'h001;
          end
        end
        default: st_ff <= `ST_IDLE;
      endcase
    end
  end

  // pin drive enables follow the role and the transmit switch
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_oe_ff <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      sck_oe_ff <= master_ff; // [RQ10]
      mosi_oe_ff <= master_ff & talk_ff; // [RQ10] [RQ16]
      miso_oe_ff <= ~master_ff & talk_ff & ~slave_tx_enable_line_n_in; // [RQ17]
    end
  end

  // outputs straight from flip-flops
  assign rdata = rdata_ff;
  assign serial_clock_pin_out = sck_ff;
  assign serial_clock_pin_oe = sck_oe_ff;
  assign master_out_line_out = dout_ff;
  assign master_out_line_oe = mosi_oe_ff;
  assign master_in_line_out = dout_ff;
  assign master_in_line_oe = miso_oe_ff;
  assign slave_tx_enable_line_n_out = ste_ff;
  assign slave_tx_enable_line_n_oe = master_ff;

endmodule

/* File: design/spi_regs.vh */
// register map, field positions and timing counts of the serial shift core
`ifndef SPI_REGS_VH
`define SPI_REGS_VH

// register indices on the plain register port
`define REG_CHAR_CFG 4'h0
`define REG_OP_CTL 4'h1
`define REG_BAUD 4'h2
`define REG_TX_HI 4'h3
`define REG_TX_LO 4'h4
`define REG_RX_LO 4'h5
`define REG_RX_HI 4'h6
`define REG_STATUS 4'h7
`define REG_FIFO_CTL 4'h8

// field positions
`define CFG_POL_BIT 6
`define CTL_TALK_BIT 1
`define CTL_MASTER_BIT 2
`define CTL_PHASE_BIT 3
`define FFC_EN_BIT 6
`define STS_RX_AVAIL_BIT 0
`define STS_TX_FULL_BIT 1
`define STS_BUSY_BIT 2
`define STS_OVERRUN_BIT 3

// reset values
`define RST_WLEN 4'hF
`define RST_BAUD 7'h7F

// fifo geometry
`define FIFO_DEPTH 5'h10
`define FIFO_AW 4

// clock divider and select timing
`define BAUD_FLOOR 7'h03
`define MIN_PERIOD 8'h04
`define LEAD_SYSCLKS 9'h003

// one-hot engine states
`define ST_IDLE 4'h1
`define ST_LEAD 4'h2
`define ST_SHIFT 4'h4
`define ST_TRAIL 4'h8

`endif

/* File: dv/spi_core_monitor.sv */
// port-level checker of the serial shift core
`timescale 1ns/1ns
`include "spi_regs.vh"
module spi_core_monitor (
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [15:0] rdata,
  input wire serial_clock_pin_out,
  input wire serial_clock_pin_oe,
  input wire master_out_line_oe,
  input wire master_in_line_oe,
  input wire slave_tx_enable_line_n_in,
  input wire slave_tx_enable_line_n_out,
  input wire slave_tx_enable_line_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  reg pol_ff, pha_ff, mst_ff, sck_ff, seen_ff;
  reg [6:0] baud_ff;
  reg [7:0] hcnt_ff, lcnt_ff;
  // expected serial period, half periods and select lead from the mirrored setup
  wire [7:0] per = (baud_ff < `BAUD_FLOOR) ? `MIN_PERIOD : {1'b0, baud_ff} + 8'h01;
  wire [7:0] half_lo = per >> 1;
  wire [7:0] half_hi = per - half_lo;
  wire [7:0] lead = pha_ff ? (per << 1) - 8'h03 : per + half_lo - 8'h03;
  wire tgl = serial_clock_pin_out != sck_ff;
  wire ste = slave_tx_enable_line_n_out;
  // mirror of the configuration and edge timers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pol_ff <= 1'b0;
      pha_ff <= 1'b0;
      mst_ff <= 1'b0;
      baud_ff <= `RST_BAUD;
      sck_ff <= 1'b0;
      seen_ff <= 1'b0;
      hcnt_ff <= 8'h00;
      lcnt_ff <= 8'h00;
    end else begin
      if (wr_stb && addr == `REG_CHAR_CFG) pol_ff <= wdata[`CFG_POL_BIT];
      if (wr_stb && addr == `REG_OP_CTL) pha_ff <= wdata[`CTL_PHASE_BIT];
      if (wr_stb && addr == `REG_OP_CTL) mst_ff <= wdata[`CTL_MASTER_BIT];
      if (wr_stb && addr == `REG_BAUD) baud_ff <= wdata[6:0];
      sck_ff <= serial_clock_pin_out;
      seen_ff <= ste ? 1'b0 : (tgl | seen_ff);
      hcnt_ff <= tgl ? 8'h01 : hcnt_ff + 8'h01;
      lcnt_ff <= ste ? 8'h00 : lcnt_ff + 8'h01;
    end
  end
  sequence s_read_baud;
    rd_stb && addr == `REG_BAUD;
  endsequence
  sequence s_select_rise;
    $rose(ste) && seen_ff;
  endsequence
  a_upper_byte_zero: assert property (rdata[15:8] == 8'h00)
    else $error("read data upper byte not zero");
  a_baud_read_back: assert property (s_read_baud |=> rdata == {9'h000, $past(baud_ff)})
    else $error("divider read back wrong");
  a_slave_no_clock: assert property (!mst_ff && !$past(mst_ff) |-> !serial_clock_pin_oe)
    else $error("slave drives serial clock");
  a_select_oe_role: assert property (slave_tx_enable_line_n_oe == mst_ff)
    else $error("select drive does not follow role");
  a_one_data_driver: assert property (!(master_out_line_oe && master_in_line_oe))
    else $error("both data lines driven");
  a_sck_idle_level: assert property (mst_ff && ste && $past(ste)
    |-> serial_clock_pin_out == $past(pol_ff))
    else $error("serial clock idle level wrong");
  a_lead_time: assert property (mst_ff && !seen_ff && tgl && !ste |-> lcnt_ff == lead)
    else $error("select lead before first clock edge wrong");
  a_half_period: assert property (seen_ff && tgl && !ste
    |-> hcnt_ff == (((serial_clock_pin_out == pol_ff) ^ pha_ff) ? half_hi : half_lo))
    else $error("serial clock half period wrong");
  a_select_trail: assert property (s_select_rise |-> hcnt_ff == half_lo)
    else $error("select released at wrong time");
  a_slave_quiet: assert property (!mst_ff && slave_tx_enable_line_n_in
    && $past(slave_tx_enable_line_n_in) |-> !master_in_line_oe)
    else $error("deselected slave drives data");
endmodule

/* File: dv/spi_far_slave.sv */
// far-side slave model exchanging one word per select frame
`timescale 1ns/1ns
module spi_far_slave (
  input wire sck,
  input wire sel_n,
  input wire mosi,
  input wire pol,
  input wire pha,
  input wire [3:0] wlen,
  input wire [15:0] tx,
  output reg miso,
  output reg [15:0] rx
);
  integer idx = 0;
  initial miso = 1'b0;
  initial rx = 16'h0000;
  // frame start presents the first bit unless phase defers it
  always @(negedge sel_n) begin
    rx = 16'h0000;
    idx = pha ? wlen + 1 : wlen;
    if (!pha) miso = tx[wlen];
  end
  // sample on one edge, shift on the other, only inside a frame
  always @(sck) begin
    if (!sel_n && ((sck != pol) ^ pha)) rx = {rx[14:0], mosi};
    if (!sel_n && !((sck != pol) ^ pha)) idx = idx - 1;
    if (!sel_n && !((sck != pol) ^ pha) && idx >= 0) miso = tx[idx];
  end
  // released line shows the inverse of its last value
  always @(posedge sel_n) miso = ~miso;
endmodule

/* File: dv/test_spi_master_slave_shift_core.sv */
// self-checking bench of the serial shift core in master and slave roles
`timescale 1ns/1ns
`include "spi_regs.vh"
module test_spi_master_slave_shift_core;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg sck_drv = 1'b0;
  reg mosi_drv = 1'b0;
  reg sel_drv = 1'b1;
  reg [15:0] sl_rx = 16'h0000;
  reg pol = 1'b0;
  reg pha = 1'b0;
  reg [3:0] wlen = 4'hF;
  reg [6:0] baud;
  reg [15:0] far_tx = 16'h0000;
  reg [15:0] my_tx, got, lo;
  reg [31:0] rnd;
  integer n_errors = 0;
  integer checked = 0;
  integer i, k;
  wire [15:0] rdata, far_rx;
  wire sck_out, sck_oe, mo_out, mo_oe, mi_out, mi_oe, ste_out, ste_oe, miso;
  // wire levels resolved from every driver
  wire sck_w = sck_oe ? sck_out : sck_drv;
  wire ste_w = ste_oe ? ste_out : sel_drv;
  wire mo_w = mo_oe ? mo_out : mosi_drv;
  wire mi_w = mi_oe ? mi_out : miso;
  always #50 clk = ~clk;
  spi_master_slave_shift_core i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .serial_clock_pin_in(sck_w),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .master_out_line_in(mo_w),
    .master_out_line_out(mo_out), .master_out_line_oe(mo_oe), .master_in_line_in(mi_w),
    .master_in_line_out(mi_out), .master_in_line_oe(mi_oe), .slave_tx_enable_line_n_in(ste_w),
    .slave_tx_enable_line_n_out(ste_out), .slave_tx_enable_line_n_oe(ste_oe));
  spi_far_slave i_far (.sck(sck_w), .sel_n(ste_w), .mosi(mo_w), .pol(pol), .pha(pha),
    .wlen(wlen), .tx(far_tx), .miso(miso), .rx(far_rx));
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input [3:0] a, output [15:0] d);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task check(input string what, input [15:0] seen, input [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // received word keeps only the programmed number of low bits
  function [15:0] keep_bits(input [15:0] v, input [3:0] w);
    keep_bits = v & (16'hFFFF >> (4'hF - w));
  endfunction
  // hang guard
  initial begin
    #6000000;
    n_errors = n_errors + 1;
    report_and_stop;
  end
  // main sequence
  initial begin
    rnd = $urandom(32'h823d63d8);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(`REG_BAUD, got);
    check("baud reset", got, 16'h007F);
    wr(`REG_BAUD, 16'hFF05);
    rd(`REG_BAUD, got);
    check("baud upper", got, 16'h0005);
    rd(4'hF, got);
    check("unmapped", got, 16'h0000);
    wr(`REG_CHAR_CFG, 16'h0000);
    wr(`REG_OP_CTL, 16'h0002);
    repeat (8) @(posedge clk) {sck_drv, mosi_drv} <= {~sck_drv, sck_drv};
    rd(`REG_STATUS, got);
    check("deselected slave rx", got & 16'h0001, 16'h0000);
    for (i = 0; i < 12; i = i + 1) begin
      rnd = $urandom;
      {pha, pol} = rnd[1:0];
      wlen = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : rnd[5:2];
      baud = (i == 2) ? 7'h7F : {3'b000, rnd[9:6]};
      far_tx = $urandom;
      my_tx = $urandom;
      wr(`REG_CHAR_CFG, {9'h000, pol, 2'b00, wlen});
      wr(`REG_BAUD, {9'h000, baud});
      wr(`REG_OP_CTL, {12'h000, pha, 3'b110});
      wr(`REG_TX_HI, {8'h00, my_tx[15:8]});
      wr(`REG_TX_LO, {8'h00, my_tx[7:0]});
      got = 16'h0004;
      for (k = 0; k < 1000 && (!got[0] || got[2]); k = k + 1) rd(`REG_STATUS, got);
      check("rx avail", got & 16'h0005, 16'h0001);
      rd(`REG_RX_LO, lo);
      rd(`REG_RX_HI, got);
      check("master rx", {got[7:0], lo[7:0]}, keep_bits(far_tx, wlen));
      check("far rx", far_rx, keep_bits(my_tx, wlen));
    end
    // slave role: the bench selects and clocks one byte, phase 0, polarity 0
    pol = 1'b0;
    pha = 1'b0;
    wlen = 4'h7;
    far_tx = $urandom;
    my_tx = $urandom;
    wr(`REG_CHAR_CFG, 16'h0007);
    wr(`REG_OP_CTL, 16'h0002);
    wr(`REG_TX_HI, {8'h00, my_tx[15:8]});
    wr(`REG_TX_LO, {8'h00, my_tx[7:0]});
    @(posedge clk) sel_drv <= 1'b0;
    repeat (2) @(posedge clk);
    for (k = 7; k >= 0; k = k - 1) begin
      @(posedge clk) mosi_drv <= far_tx[k];
      repeat (2) @(posedge clk);
      sl_rx = {sl_rx[14:0], mi_w};
      sck_drv <= 1'b1;
      repeat (2) @(posedge clk);
      sck_drv <= 1'b0;
    end
    repeat (2) @(posedge clk);
    sel_drv <= 1'b1;
    check("slave tx", sl_rx & 16'h00FF, {8'h00, my_tx[7:0]});
    rd(`REG_RX_LO, lo);
    rd(`REG_RX_HI, got);
    check("slave rx", {got[7:0], lo[7:0]}, keep_bits(far_tx, 4'h7));
    wr(`REG_OP_CTL, 16'h0000);
    wr(`REG_TX_LO, 16'h005A);
    rd(`REG_STATUS, got);
    check("bypass full", got & 16'h0002, 16'h0002);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    wr(`REG_FIFO_CTL, 16'h0040);
    for (k = 0; k < 17; k = k + 1) wr(`REG_TX_LO, k[15:0]);
    rd(`REG_FIFO_CTL, got);
    check("fifo level", got & 16'h005F, 16'h0050);
    rd(`REG_STATUS, got);
    check("fifo full", got & 16'h0002, 16'h0002);
    report_and_stop;
  end
endmodule
bind spi_master_slave_shift_core spi_core_monitor i_mon (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .master_out_line_oe(master_out_line_oe), .master_in_line_oe(master_in_line_oe),
  .slave_tx_enable_line_n_in(slave_tx_enable_line_n_in),
  .slave_tx_enable_line_n_out(slave_tx_enable_line_n_out),
  .slave_tx_enable_line_n_oe(slave_tx_enable_line_n_oe));
